// file: hw/ioh_pkg.sv
// Constants shared by the channel-pair handshake block and its helpers.
// Assumes a single 10 MHz clock; times are converted to cycle counts here.
package ioh_pkg;
   // Link, word-count and timer widths
   localparam int DATA_W = 30;
   localparam int CNT_W = 15;
   localparam int TMR_W = 16;

   // Clock period in nanoseconds
   localparam int CLK_NS = 100;

   // Least time the shared output register holds a word on a peripheral channel
   localparam int HOLD_NS = 2000;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;

   // Intercomputer time-out for a forced function nobody accepts
   localparam int TIMEOUT_NS = 100000;
   localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;

   // Reset values
   localparam logic [DATA_W-1:0] DATA_RST = 30'h0;
   localparam logic [CNT_W-1:0] CNT_RST = 15'h0;
   localparam logic IRQ_EN_RST = 1'b1;

   // Output sequencer states
   typedef enum logic [2:0] {
      OS_IDLE,
      OS_CLEAR,
      OS_PLACE,
      OS_STROBE,
      OS_RELEASE
   } ioh_out_state_type;

   // Input sequencer states
   typedef enum logic [1:0] {
      IS_IDLE,
      IS_DATA_ACK,
      IS_IRQ_ACK
   } ioh_in_state_type;
endpackage : ioh_pkg

// file: hw/ioh_word_counter.sv
// Word counter for one buffer: loaded by the program, counted down per word.
// Assumes load and dec are one-cycle pulses from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ioh_word_counter (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [ioh_pkg::CNT_W-1:0] count_in,
   input wire logic dec,
   output logic active
);
   logic [ioh_pkg::CNT_W-1:0] count_ff;

   // Load wins over a decrement in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_ff <= ioh_pkg::CNT_RST;
      end else if (load) begin
         count_ff <= count_in;
      end else if (dec && count_ff != ioh_pkg::CNT_RST) begin
         count_ff <= count_ff - 15'h1;
      end
   end

   assign active = (count_ff != ioh_pkg::CNT_RST);
endmodule : ioh_word_counter
`default_nettype wire

// file: hw/ioh_cycle_timer.sv
// Down-counting one-shot: done goes high LEN cycles after start.
// Assumes start is a one-cycle pulse; done is only meaningful after a start.
`timescale 1ns/1ps
`default_nettype none
module ioh_cycle_timer #(
   parameter int unsigned LEN = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic done
);
   logic [ioh_pkg::TMR_W-1:0] cnt_ff;

   // Restart on every start pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (start) begin
         cnt_ff <= ioh_pkg::TMR_W'(LEN);
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 16'h1;
      end
   end

   assign done = (cnt_ff == '0) && !start;
endmodule : ioh_cycle_timer
`default_nettype wire

// file: hw/ioh_channel.sv
// Handshake logic for one 30-bit input/output channel pair, computer side.
// Assumes all link and user inputs are synchronous to MCLK.
// Summary of operation
// - On output request: clear, place word, raise strobe
// - Drop strobe per word until count done
// - On function request: clear, place, raise strobe
// - Drop function strobe per word until count done
// - Sample input word on the edge the acknowledge rises
// - Raise interrupt enable when ready for interrupt
// - Acknowledge interrupt while dropping interrupt enable
// - Interrupt enable set by clear or instruction
// - Peripheral channel holds word a minimum time
// - Intercomputer: hold data until resume arrives
// - Intercomputer command: enable as request, resume ends
// - Forced function without enable stalls until time-out
// - Intercomputer data: ready, then resume clears
`timescale 1ns/1ps
`default_nettype none
module ioh_channel (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic INTERCOMPUTER,
   input wire logic OUT_START,
   input wire logic [ioh_pkg::CNT_W-1:0] OUT_COUNT,
   input wire logic [ioh_pkg::DATA_W-1:0] OUT_WORD,
   output logic OUT_WORD_NEXT,
   output logic OUT_BUSY,
   input wire logic FUNC_START,
   input wire logic [ioh_pkg::CNT_W-1:0] FUNC_COUNT,
   input wire logic FUNC_FORCE,
   input wire logic [ioh_pkg::DATA_W-1:0] FUNC_WORD,
   output logic FUNC_WORD_NEXT,
   output logic FUNC_BUSY,
   output logic STALL,
   output logic TIMEOUT_IRQ,
   input wire logic IN_START,
   input wire logic [ioh_pkg::CNT_W-1:0] IN_COUNT,
   output logic IN_BUSY,
   output logic [ioh_pkg::DATA_W-1:0] IN_WORD,
   output logic IN_WORD_VALID,
   output logic IRQ_WORD_VALID,
   input wire logic IRQ_ARM,
   output logic [ioh_pkg::DATA_W-1:0] OUT_DATA_LINES,
   input wire logic OUT_WORD_REQUEST,
   output logic OUT_WORD_STROBE,
   input wire logic FUNC_WORD_REQUEST,
   output logic FUNC_WORD_STROBE,
   input wire logic [ioh_pkg::DATA_W-1:0] IN_DATA_LINES,
   input wire logic IN_WORD_REQUEST,
   output logic IN_WORD_ACK,
   input wire logic EXT_IRQ,
   output logic IRQ_ENABLE
);
   localparam int TO_MAX = ioh_pkg::TIMEOUT_CYC + 2;

   ioh_pkg::ioh_out_state_type out_state_ff;
   ioh_pkg::ioh_in_state_type in_state_ff;
   logic [ioh_pkg::DATA_W-1:0] data_ff;
   logic sel_func_ff;
   logic forced_ff;
   logic force_pend_ff;
   logic out_strobe_ff;
   logic func_strobe_ff;
   logic stall_ff;
   logic timeout_ff;
   logic out_next_ff;
   logic func_next_ff;
   logic [ioh_pkg::DATA_W-1:0] in_word_ff;
   logic in_valid_ff;
   logic irq_valid_ff;
   logic in_ack_ff;
   logic irq_en_ff;
   logic out_active;
   logic func_active;
   logic in_active;
   logic hold_done;
   logic to_done;
   logic timer_start;
   logic out_go;
   logic func_go;
   logic resume;
   logic in_dec;

   // Resume shares the output request line in intercomputer mode
   assign resume = INTERCOMPUTER && OUT_WORD_REQUEST;
   // Intercomputer output waits only for the resume line to be idle
   assign out_go = out_active && (INTERCOMPUTER ? !OUT_WORD_REQUEST : OUT_WORD_REQUEST);
   // Receiver enable acts as function request in intercomputer mode
   assign func_go = func_active && FUNC_WORD_REQUEST;
   assign timer_start = (out_state_ff == ioh_pkg::OS_PLACE);

   ioh_word_counter u_out_cnt (
      .clk(MCLK),
      .rst(RESET),
      .load(OUT_START),
      .count_in(OUT_COUNT),
      .dec(timer_start && !sel_func_ff),
      .active(out_active)
   );

   ioh_word_counter u_func_cnt (
      .clk(MCLK),
      .rst(RESET),
      .load(FUNC_START),
      .count_in(FUNC_COUNT),
      .dec(timer_start && sel_func_ff && !forced_ff),
      .active(func_active)
   );

   ioh_word_counter u_in_cnt (
      .clk(MCLK),
      .rst(RESET),
      .load(IN_START),
      .count_in(IN_COUNT),
      .dec(in_dec),
      .active(in_active)
   );

   ioh_cycle_timer #(.LEN(ioh_pkg::HOLD_CYC)) u_hold (
      .clk(MCLK),
      .rst(RESET),
      .start(timer_start),
      .done(hold_done)
   );

   ioh_cycle_timer #(.LEN(ioh_pkg::TIMEOUT_CYC)) u_timeout (
      .clk(MCLK),
      .rst(RESET),
      .start(timer_start),
      .done(to_done)
   );

   // A forced function waits here until the sequencer is free; the pulse is not lost
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         force_pend_ff <= 1'b0;
      end else if (FUNC_FORCE) begin
         force_pend_ff <= 1'b1;
      end else if (out_state_ff == ioh_pkg::OS_IDLE) begin
         force_pend_ff <= 1'b0;
      end
   end

   // Output sequencer: one shared data register serves data and function words
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         out_state_ff <= ioh_pkg::OS_IDLE;
         data_ff <= ioh_pkg::DATA_RST;
         sel_func_ff <= 1'b0;
         forced_ff <= 1'b0;
         out_strobe_ff <= 1'b0;
         func_strobe_ff <= 1'b0;
         stall_ff <= 1'b0;
      end else begin
         case (out_state_ff)
            ioh_pkg::OS_IDLE: begin
               // Forced function first, then function buffer, then data
               if (force_pend_ff) begin
                  sel_func_ff <= 1'b1;
                  forced_ff <= 1'b1;
                  out_state_ff <= ioh_pkg::OS_CLEAR;
               end else if (func_go) begin
                  sel_func_ff <= 1'b1;
                  forced_ff <= 1'b0;
                  out_state_ff <= ioh_pkg::OS_CLEAR;
               end else if (out_go) begin
                  sel_func_ff <= 1'b0;
                  forced_ff <= 1'b0;
                  out_state_ff <= ioh_pkg::OS_CLEAR;
               end
            end
            ioh_pkg::OS_CLEAR: begin
               data_ff <= ioh_pkg::DATA_RST;
               out_state_ff <= ioh_pkg::OS_PLACE;
            end
            ioh_pkg::OS_PLACE: begin
               // Word goes out on the same edge its strobe rises, one cycle after the clear
               data_ff <= sel_func_ff ? FUNC_WORD : OUT_WORD;
               out_strobe_ff <= !sel_func_ff;
               func_strobe_ff <= sel_func_ff;
               stall_ff <= INTERCOMPUTER && forced_ff && !FUNC_WORD_REQUEST;
               out_state_ff <= ioh_pkg::OS_STROBE;
            end
            ioh_pkg::OS_STROBE: begin
               if (!INTERCOMPUTER) begin
                  // Data stays on the lines after the strobe until replaced
                  if (hold_done) begin
                     out_strobe_ff <= 1'b0;
                     func_strobe_ff <= 1'b0;
                     out_state_ff <= ioh_pkg::OS_IDLE;
                  end
               end else if (resume || (stall_ff && to_done)) begin
                  // Receiver took it, or the time-out frees the group
                  out_strobe_ff <= 1'b0;
                  func_strobe_ff <= 1'b0;
                  data_ff <= ioh_pkg::DATA_RST;
                  stall_ff <= 1'b0;
                  out_state_ff <= ioh_pkg::OS_RELEASE;
               end
            end
            ioh_pkg::OS_RELEASE: begin
               // Wait for resume to fall so one resume never ends two words
               if (!OUT_WORD_REQUEST) begin
                  out_state_ff <= ioh_pkg::OS_IDLE;
               end
            end
            default: begin
               out_state_ff <= ioh_pkg::OS_IDLE;
            end
         endcase
      end
   end

   // Fetch pulses and the time-out event
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         out_next_ff <= 1'b0;
         func_next_ff <= 1'b0;
         timeout_ff <= 1'b0;
      end else begin
         out_next_ff <= timer_start && !sel_func_ff;
         func_next_ff <= timer_start && sel_func_ff;
         timeout_ff <= (out_state_ff == ioh_pkg::OS_STROBE) && INTERCOMPUTER && stall_ff
                       && to_done && !resume;
      end
   end

   assign in_dec = (in_state_ff == ioh_pkg::IS_IDLE) && !(EXT_IRQ && irq_en_ff)
                   && IN_WORD_REQUEST && in_active;

   // Input sequencer: interrupts take priority over buffered input
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         in_state_ff <= ioh_pkg::IS_IDLE;
         in_word_ff <= ioh_pkg::DATA_RST;
         in_ack_ff <= 1'b0;
         in_valid_ff <= 1'b0;
         irq_valid_ff <= 1'b0;
      end else begin
         in_valid_ff <= 1'b0;
         irq_valid_ff <= 1'b0;
         case (in_state_ff)
            ioh_pkg::IS_IDLE: begin
               if (EXT_IRQ && irq_en_ff) begin
                  in_word_ff <= IN_DATA_LINES;
                  in_ack_ff <= 1'b1;
                  irq_valid_ff <= 1'b1;
                  in_state_ff <= ioh_pkg::IS_IRQ_ACK;
               end else if (in_dec) begin
                  // Word is captured in the same edge the acknowledge rises
                  in_word_ff <= IN_DATA_LINES;
                  in_ack_ff <= 1'b1;
                  in_valid_ff <= 1'b1;
                  in_state_ff <= ioh_pkg::IS_DATA_ACK;
               end
            end
            ioh_pkg::IS_DATA_ACK: begin
               if (!IN_WORD_REQUEST) begin
                  in_ack_ff <= 1'b0;
                  in_state_ff <= ioh_pkg::IS_IDLE;
               end
            end
            ioh_pkg::IS_IRQ_ACK: begin
               if (!EXT_IRQ) begin
                  in_ack_ff <= 1'b0;
                  in_state_ff <= ioh_pkg::IS_IDLE;
               end
            end
            default: begin
               in_state_ff <= ioh_pkg::IS_IDLE;
            end
         endcase
      end
   end

   // Interrupt enable: master clear sets it, arming wins over the drop on accept
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         irq_en_ff <= ioh_pkg::IRQ_EN_RST;
      end else if (IRQ_ARM) begin
         irq_en_ff <= 1'b1;
      end else if (in_state_ff == ioh_pkg::IS_IDLE && EXT_IRQ && irq_en_ff) begin
         irq_en_ff <= 1'b0;
      end
   end

   assign OUT_DATA_LINES = data_ff;
   assign OUT_WORD_STROBE = out_strobe_ff;
   assign FUNC_WORD_STROBE = func_strobe_ff;
   assign IN_WORD_ACK = in_ack_ff;
   assign IRQ_ENABLE = irq_en_ff;
   assign OUT_WORD_NEXT = out_next_ff;
   assign FUNC_WORD_NEXT = func_next_ff;
   assign OUT_BUSY = out_active;
   assign FUNC_BUSY = func_active;
   assign IN_BUSY = in_active;
   assign STALL = stall_ff;
   assign TIMEOUT_IRQ = timeout_ff;
   assign IN_WORD = in_word_ff;
   assign IN_WORD_VALID = in_valid_ff;
   assign IRQ_WORD_VALID = irq_valid_ff;

   // Data strobe rises only over a word that was cleared first
   property p_out_clear;
      @(posedge MCLK) disable iff (RESET)
         $rose(OUT_WORD_STROBE) |-> $past(OUT_DATA_LINES) == ioh_pkg::DATA_RST;
   endproperty
   a_out_clear: assert property (p_out_clear) else $error("data strobe without clear");

   property p_func_clear;
      @(posedge MCLK) disable iff (RESET)
         $rose(FUNC_WORD_STROBE) |-> $past(OUT_DATA_LINES) == ioh_pkg::DATA_RST
            && $past(out_state_ff == ioh_pkg::OS_PLACE);
   endproperty
   a_func_clear: assert property (p_func_clear) else $error("function strobe without clear");

   property p_hold;
      @(posedge MCLK) disable iff (RESET)
         $fell(OUT_WORD_STROBE || FUNC_WORD_STROBE) && !$past(INTERCOMPUTER)
            |-> $past(hold_done);
   endproperty
   a_hold: assert property (p_hold) else $error("strobe dropped before hold time");

   property p_inter_hold;
      @(posedge MCLK) disable iff (RESET)
         INTERCOMPUTER && OUT_WORD_STROBE && !OUT_WORD_REQUEST
            |=> OUT_WORD_STROBE && $stable(OUT_DATA_LINES);
   endproperty
   a_inter_hold: assert property (p_inter_hold) else $error("ready dropped without resume");

   property p_func_resume;
      @(posedge MCLK) disable iff (RESET)
         $fell(FUNC_WORD_STROBE) && $past(INTERCOMPUTER) |-> $past(OUT_WORD_REQUEST) || TIMEOUT_IRQ;
   endproperty
   a_func_resume: assert property (p_func_resume) else $error("command ended without resume");

   // Stall length in cycles; the bound is too long for a delay range, so it is counted
   logic [ioh_pkg::TMR_W-1:0] stall_len_ff;
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         stall_len_ff <= '0;
      end else begin
         stall_len_ff <= stall_ff ? stall_len_ff + 16'h1 : '0;
      end
   end

   property p_stall_bound;
      @(posedge MCLK) disable iff (RESET)
         STALL |-> stall_len_ff < ioh_pkg::TMR_W'(TO_MAX);
   endproperty
   a_stall_bound: assert property (p_stall_bound) else $error("stall outlived time-out");

   property p_ack_capture;
      @(posedge MCLK) disable iff (RESET)
         $rose(IN_WORD_ACK) |-> (IN_WORD_VALID || IRQ_WORD_VALID) && IN_WORD == $past(IN_DATA_LINES);
   endproperty
   a_ack_capture: assert property (p_ack_capture) else $error("acknowledge without capture");

   property p_ack_drop;
      @(posedge MCLK) disable iff (RESET)
         $fell(IN_WORD_ACK) |-> $past(!IN_WORD_REQUEST) || $past(!EXT_IRQ);
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("acknowledge dropped early");

   property p_irq_ack;
      @(posedge MCLK) disable iff (RESET)
         IRQ_WORD_VALID && !$past(IRQ_ARM) |-> $rose(IN_WORD_ACK) && $fell(IRQ_ENABLE);
   endproperty
   a_irq_ack: assert property (p_irq_ack) else $error("interrupt ack not with enable drop");

   property p_arm;
      @(posedge MCLK) disable iff (RESET)
         IRQ_ARM |=> IRQ_ENABLE;
   endproperty
   a_arm: assert property (p_arm) else $error("arm did not set enable");
endmodule : ioh_channel
`default_nettype wire

// file: verif/ioh_peer.sv
// Far-side model: a peripheral, or the receiving computer in intercomputer mode.
// Assumes bench controls are synchronous to the clock; able and able_f slow its answers.
`timescale 1ns/1ps
`default_nettype none
module ioh_peer (
   input wire logic clk,
   input wire logic rst,
   input wire logic ic,
   input wire logic able,
   input wire logic able_f,
   input wire logic in_go,
   input wire logic irq_go,
   input wire logic [ioh_pkg::DATA_W-1:0] in_val,
   input wire logic [ioh_pkg::DATA_W-1:0] out_lines,
   input wire logic out_strobe,
   input wire logic func_strobe,
   input wire logic in_ack,
   input wire logic irq_en,
   output logic out_req,
   output logic func_req,
   output logic in_req,
   output logic ext_irq,
   output logic [ioh_pkg::DATA_W-1:0] in_lines,
   output logic [ioh_pkg::DATA_W-1:0] got_word
);
   logic out_req_ff, func_req_ff, in_req_ff, irq_ff, strobe_ff;
   logic [1:0] pend_ff;
   logic [ioh_pkg::DATA_W-1:0] lines_ff, got_ff;

   assign out_req = out_req_ff;
   assign func_req = func_req_ff;
   assign in_req = in_req_ff;
   assign ext_irq = irq_ff;
   assign in_lines = lines_ff;
   assign got_word = got_ff;

   // Request only while able, dropped once the strobe is seen; resume answers ready
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_req_ff <= 1'b0;
         func_req_ff <= 1'b0;
      end else begin
         out_req_ff <= ic ? (able && (out_strobe || func_strobe)) : (able && !out_strobe);
         func_req_ff <= able_f && !func_strobe;
      end
   end

   // Sample as a strobe rises, so forced words are taken the same way
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_ff <= 1'b0;
         got_ff <= ioh_pkg::DATA_RST;
      end else begin
         strobe_ff <= out_strobe || func_strobe;
         if ((out_strobe || func_strobe) && !strobe_ff) got_ff <= out_lines;
      end
   end

   // Word placed a cycle before its request; released lines toggle so stale data cannot match
   // Interrupts ignore the enable, as a unit without enable logic would
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_req_ff <= 1'b0;
         irq_ff <= 1'b0;
         pend_ff <= 2'h0;
         lines_ff <= ioh_pkg::DATA_RST;
      end else if (in_ack && (in_req_ff || (irq_ff && !irq_en))) begin
         in_req_ff <= 1'b0;
         irq_ff <= 1'b0;
         lines_ff <= ~lines_ff;
      end else if (pend_ff != 2'h0) begin
         in_req_ff <= pend_ff[0];
         irq_ff <= pend_ff[1];
         pend_ff <= 2'h0;
      end else if (!in_req_ff && !irq_ff && !in_ack && (in_go || irq_go)) begin
         lines_ff <= in_val;
         pend_ff <= {irq_go, !irq_go};
      end else if (!in_req_ff && !irq_ff) begin
         lines_ff <= ~lines_ff;
      end
   end
endmodule : ioh_peer
`default_nettype wire

// file: verif/io_channel_handshake_tb_top.sv
// Self-checking bench for the channel-pair handshake block.
// Assumes the package, design modules and peer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module io_channel_handshake_tb_top;
   localparam logic [ioh_pkg::DATA_W-1:0] FW = 30'h2bcd0123;
   localparam logic [ioh_pkg::DATA_W-1:0] IW = 30'h15a5a5a5;
   localparam logic [ioh_pkg::DATA_W-1:0] IQ = 30'h0c3c3c3c;
   logic MCLK, RESET, INTERCOMPUTER, OUT_START, FUNC_START, FUNC_FORCE, IN_START, IRQ_ARM;
   logic [ioh_pkg::CNT_W-1:0] OUT_COUNT, FUNC_COUNT, IN_COUNT;
   logic [ioh_pkg::DATA_W-1:0] OUT_WORD, FUNC_WORD, IN_WORD, OUT_DATA_LINES, IN_DATA_LINES;
   logic [ioh_pkg::DATA_W-1:0] got_word, in_val, last_lines;
   logic OUT_WORD_NEXT, OUT_BUSY, FUNC_WORD_NEXT, FUNC_BUSY, STALL, TIMEOUT_IRQ, IN_BUSY;
   logic IN_WORD_VALID, IRQ_WORD_VALID, OUT_WORD_REQUEST, OUT_WORD_STROBE, FUNC_WORD_REQUEST;
   logic FUNC_WORD_STROBE, IN_WORD_REQUEST, IN_WORD_ACK, EXT_IRQ, IRQ_ENABLE;
   logic able, able_f, in_go, irq_go;
   int bad_count, comparisons;

   ioh_channel DUT (.MCLK, .RESET, .INTERCOMPUTER, .OUT_START, .OUT_COUNT, .OUT_WORD,
      .OUT_WORD_NEXT, .OUT_BUSY, .FUNC_START, .FUNC_COUNT, .FUNC_FORCE, .FUNC_WORD,
      .FUNC_WORD_NEXT, .FUNC_BUSY, .STALL, .TIMEOUT_IRQ, .IN_START, .IN_COUNT, .IN_BUSY,
      .IN_WORD, .IN_WORD_VALID, .IRQ_WORD_VALID, .IRQ_ARM, .OUT_DATA_LINES, .OUT_WORD_REQUEST,
      .OUT_WORD_STROBE, .FUNC_WORD_REQUEST, .FUNC_WORD_STROBE, .IN_DATA_LINES,
      .IN_WORD_REQUEST, .IN_WORD_ACK, .EXT_IRQ, .IRQ_ENABLE);

   ioh_peer peer (.clk(MCLK), .rst(RESET), .ic(INTERCOMPUTER), .able(able), .able_f(able_f),
      .in_go(in_go), .irq_go(irq_go), .in_val(in_val), .out_lines(OUT_DATA_LINES),
      .out_strobe(OUT_WORD_STROBE), .func_strobe(FUNC_WORD_STROBE), .in_ack(IN_WORD_ACK),
      .irq_en(IRQ_ENABLE), .out_req(OUT_WORD_REQUEST), .func_req(FUNC_WORD_REQUEST),
      .in_req(IN_WORD_REQUEST), .ext_irq(EXT_IRQ), .in_lines(IN_DATA_LINES),
      .got_word(got_word));

   initial begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end

   // Next output word once the current one is consumed; remember last cycle's lines
   always @(posedge MCLK) begin
      last_lines <= OUT_DATA_LINES;
      if (OUT_WORD_NEXT === 1'b1) OUT_WORD <= OUT_WORD + 30'h1;
   end

   task automatic end_of_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_word(input logic [29:0] got, input logic [29:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %b", $time, what, got);
      end
   endtask : chk_bit

   function automatic logic sig(input int w);
      case (w)
         0: sig = OUT_WORD_STROBE;
         1: sig = FUNC_WORD_STROBE;
         2: sig = IN_WORD_VALID;
         3: sig = IRQ_WORD_VALID;
         4: sig = STALL;
         5: sig = TIMEOUT_IRQ;
         default: sig = IN_WORD_ACK;
      endcase
   endfunction : sig

   // Bounded wait; n counts the edges it took
   task automatic wait_on(input int w, input logic lvl, input int lim, output int n);
      n = 0;
      #1;
      while (sig(w) !== lvl) begin
         @(posedge MCLK);
         #1;
         n++;
         if (n > lim) begin
            bad_count++;
            $display("wrong value at %0t: wait %0d ran out", $time, w);
            end_of_test();
         end
      end
   endtask : wait_on

   // One-cycle pulse on a program control or a peer go line (in_go, irq_go)
   task automatic kick(input int w);
      @(posedge MCLK);
      OUT_START <= (w == 0);
      FUNC_START <= (w == 1);
      FUNC_FORCE <= (w == 2);
      IN_START <= (w == 3);
      IRQ_ARM <= (w == 4);
      in_go <= (w == 5);
      irq_go <= (w == 6);
      @(posedge MCLK);
      {OUT_START, FUNC_START, FUNC_FORCE, IN_START, IRQ_ARM, in_go, irq_go} <= 7'h0;
   endtask : kick

   // Two peripheral words: clear, place, strobe for the hold time, then stop
   task automatic t_out();
      logic [29:0] w;
      int n;
      w = OUT_WORD;
      kick(0);
      able <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wait_on(0, 1'b1, 40, n);
         chk_word(last_lines, 30'h0, "lines cleared first");
         chk_word(OUT_DATA_LINES, w + 30'(k), "output word");
         wait_on(0, 1'b0, 40, n);
         chk_word(30'(n), 30'(ioh_pkg::HOLD_CYC + 1), "strobe length");
         chk_word(got_word, w + 30'(k), "peer sample");
      end
      repeat (30) @(posedge MCLK);
      able <= 1'b0;
      #1;
      chk_bit(OUT_WORD_STROBE | OUT_BUSY, 1'b0, "no word past count");
   endtask : t_out

   // Requested function word, then a forced one to a requestless peripheral
   task automatic t_func();
      int n;
      kick(1);
      able_f <= 1'b1;
      wait_on(1, 1'b1, 40, n);
      chk_word(OUT_DATA_LINES, FW, "function word");
      chk_bit(FUNC_WORD_NEXT, 1'b1, "function word consumed");
      wait_on(1, 1'b0, 40, n);
      chk_bit(FUNC_BUSY, 1'b0, "function count done");
      @(posedge MCLK);
      able_f <= 1'b0;
      FUNC_WORD <= ~FW;
      kick(2);
      wait_on(1, 1'b1, 40, n);
      chk_word(OUT_DATA_LINES, ~FW, "forced word");
      wait_on(1, 1'b0, 40, n);
      chk_word(got_word, ~FW, "forced word sampled");
   endtask : t_func

   // Data word in, then an interrupt word, then one while the enable is down
   task automatic t_input();
      int n;
      kick(3);
      in_val <= IW;
      kick(5);
      wait_on(2, 1'b1, 10, n);
      chk_word(IN_WORD, IW, "input word");
      chk_bit(IN_WORD_ACK, 1'b1, "input ack");
      wait_on(6, 1'b0, 10, n);
      chk_bit(IN_WORD_REQUEST | IN_BUSY, 1'b0, "ack drops after request");
      @(posedge MCLK);
      in_val <= IQ;
      kick(6);
      wait_on(3, 1'b1, 10, n);
      chk_word(IN_WORD, IQ, "interrupt word");
      chk_bit(IN_WORD_ACK & ~IRQ_ENABLE, 1'b1, "ack with enable drop");
      wait_on(6, 1'b0, 10, n);
      kick(6);
      repeat (5) @(posedge MCLK);
      #1;
      chk_bit(IN_WORD_ACK, 1'b0, "no accept while disabled");
      kick(4);
      #1;
      chk_bit(IRQ_ENABLE, 1'b1, "enable rearmed");
      wait_on(3, 1'b1, 5, n);
      chk_word(IN_WORD, IQ, "held interrupt taken once armed");
      wait_on(6, 1'b0, 10, n);
   endtask : t_input

   // Intercomputer data held past the hold time until resume, then cleared
   task automatic t_ic_data();
      logic [29:0] w;
      int n;
      @(posedge MCLK);
      INTERCOMPUTER <= 1'b1;
      w = OUT_WORD;
      kick(0);
      for (int k = 0; k < 2; k++) begin
         wait_on(0, 1'b1, 20, n);
         repeat (30) @(posedge MCLK);
         #1;
         chk_word(OUT_DATA_LINES, w + 30'(k), "data held for resume");
         chk_bit(OUT_WORD_STROBE, 1'b1, "ready held");
         @(posedge MCLK);
         able <= 1'b1;
         wait_on(0, 1'b0, 5, n);
         @(posedge MCLK);
         able <= 1'b0;
         #1;
         chk_word(OUT_DATA_LINES, 30'h0, "lines cleared on resume");
         chk_word(got_word, w + 30'(k), "receiver sample");
      end
   endtask : t_ic_data

   // Forced command with the receiver disabled stalls the group until time-out
   task automatic t_stall();
      int n;
      kick(2);
      wait_on(4, 1'b1, 10, n);
      kick(0);
      repeat (50) @(posedge MCLK);
      #1;
      chk_bit(OUT_WORD_STROBE, 1'b0, "group suspended");
      chk_bit(FUNC_WORD_STROBE, 1'b1, "forced strobe held");
      wait_on(5, 1'b1, 1100, n);
      wait_on(4, 1'b0, 3, n);
      wait_on(0, 1'b1, 20, n);
      @(posedge MCLK);
      able <= 1'b1;
      able_f <= 1'b1;
      FUNC_WORD <= FW;
      wait_on(0, 1'b0, 5, n);
      wait_on(0, 1'b1, 20, n);
      wait_on(0, 1'b0, 5, n);
      kick(1);
      wait_on(1, 1'b1, 20, n);
      wait_on(1, 1'b0, 5, n);
      chk_word(got_word, FW, "command taken on enable");
   endtask : t_stall

   initial begin
      RESET = 1'b1;
      {OUT_START, FUNC_START, FUNC_FORCE, IN_START, IRQ_ARM, in_go, irq_go} = 7'h0;
      {able, able_f, INTERCOMPUTER} = 3'h0;
      OUT_COUNT = 15'h2;
      FUNC_COUNT = 15'h1;
      IN_COUNT = 15'h1;
      OUT_WORD = 30'h01234560;
      FUNC_WORD = FW;
      in_val = 30'h0;
      bad_count = 0;
      comparisons = 0;
      repeat (16) @(posedge MCLK);
      RESET <= 1'b0;
      @(posedge MCLK);
      #1;
      chk_bit(IRQ_ENABLE, 1'b1, "enable after clear");
      chk_bit(IN_WORD_ACK | OUT_WORD_STROBE | FUNC_WORD_STROBE, 1'b0, "quiet after clear");
      t_out();
      t_func();
      t_input();
      t_ic_data();
      t_stall();
      end_of_test();
   end
endmodule : io_channel_handshake_tb_top
`default_nettype wire
